// File: bench/acm_ctrl_chk.sv
// Assertion checker for the converter control block, bound to its ports.
// Assumes clock select changes only while conversion is halted.
module acm_ctrl_chk (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Register bus.
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    input wire logic [31:0] wbDatO,
    input wire logic wbAck,
    // Triggers and status.
    input wire logic pulseTimerTrig,
    input wire logic eightBitTimerTrig,
    input wire logic externalTriggerPinN,
    input wire logic converting,
    input wire logic endFlag
);
    timeunit 1ns;
    timeprecision 1ns;
    import acm_pkg::*;
    logic [5:0] tm;
    logic chanHi;
    logic [9:0] runCnt;
    logic [9:0] lim;
    logic take;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the fields, caught at the edge where the design takes a write.
    assign take = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tm <= 6'h00;
            chanHi <= 1'h0;
        end else if (take && wbAdr == 8'h04) begin
            tm <= wbDatI[7:2];
        end else if (take && wbAdr == 8'h00) begin
            chanHi <= wbDatI[3];
        end
    end
    // Length of the current run of converting, compared when it ends.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            runCnt <= 10'h000;
        end else begin
            runCnt <= converting ? runCnt + 10'h001 : 10'h000;
        end
    end
    assign lim = tm[1] ? (tm[0] ? 10'h044 : 10'h086) : (tm[0] ? 10'h10A : 10'h212);
    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    AST_ACK_REG: assert property ($rose(wbStb) && (wbAdr < 8'h20 || wbAdr > 8'h3C) |=> wbAck)
        else $error("register ack late");
    AST_ACK_RES: assert property ($rose(wbStb) && !wbWe && wbAdr inside {[8'h20:8'h3C]}
        |=> !wbAck ##1 wbAck) else $error("result ack timing");
    AST_RSV_ZERO: assert property ($rose(wbStb) && !wbWe && wbAdr == 8'h04
        |=> wbDatO[1:0] == 2'h0) else $error("reserved bits not zero");
    AST_SW_START: assert property (take && wbAdr == 8'h00 && wbDatI[5] && !wbDatI[3]
        && !converting |-> ##[1:3] converting) else $error("software start lost");
    AST_NO_TRIG: assert property (tm[5:4] == 2'h0 && !converting && !wbCyc
        && (pulseTimerTrig || eightBitTimerTrig || !externalTriggerPinN)
        |=> !converting [*6]) else $error("trigger not ignored");
    AST_TMR_TRIG: assert property (!converting && !chanHi && (tm[5:4] == 2'h1
        && pulseTimerTrig || tm[5:4] == 2'h2 && eightBitTimerTrig)
        |-> ##[1:3] converting) else $error("timer trigger lost");
    AST_PIN_TRIG: assert property (tm[5:4] == 2'h3 && !converting && !chanHi
        && $fell(externalTriggerPinN) |-> ##[2:8] converting) else $error("pin trigger lost");
    AST_CONV_LEN: assert property ($fell(converting) && !tm[3] |-> runCnt == lim)
        else $error("conversion length wrong");
    AST_PROHIB: assert property (take && wbAdr == 8'h00 && wbDatI[5] && wbDatI[3]
        && !converting |=> !converting [*8]) else $error("prohibited code converts");
    CVR_SCAN_END: cover property ($rose(endFlag) && tm[3]);
    CVR_PIN: cover property ($fell(externalTriggerPinN) && tm[5:4] == 2'h3);
    CVR_SLOW: cover property ($rose(converting) && tm[1:0] == 2'h0);
endmodule : acm_ctrl_chk

bind acm_ctrl acm_ctrl_chk acm_ctrl_chk_inst (.clock, .nrst, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatI, .wbDatO, .wbAck, .pulseTimerTrig, .eightBitTimerTrig,
    .externalTriggerPinN, .converting, .endFlag);

// File: bench/acm_trig_src.sv
// Trigger sources facing the converter control: two timers and the trigger pin.
// Assumes the bench asks for one firing at a time with a one-cycle request.
module acm_trig_src (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Firing request: 1 pulse timer, 2 eight-bit timer, 3 pin.
    input wire logic fire,
    input wire logic [1:0] fireCode,
    // Trigger outputs.
    output logic pulseTimerTrig,
    output logic eightBitTimerTrig,
    output logic externalTriggerPinN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] lowCnt;
    // Timer triggers are one-cycle pulses on the shared clock.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pulseTimerTrig <= 1'h0;
            eightBitTimerTrig <= 1'h0;
        end else begin
            pulseTimerTrig <= fire && fireCode == 2'h1;
            eightBitTimerTrig <= fire && fireCode == 2'h2;
        end
    end
    // The pin stays low four cycles so a slow synchroniser cannot miss it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lowCnt <= 3'h0;
        end else if (fire && fireCode == 2'h3) begin
            lowCnt <= 3'h4;
        end else if (lowCnt != 3'h0) begin
            lowCnt <= lowCnt - 3'h1;
        end
    end
    // Idle level is the pull-up level.
    assign externalTriggerPinN = (lowCnt == 3'h0);
endmodule : acm_trig_src

// File: bench/tb_adc_channel_mode_trigger_ctrl.sv
// Self-checking bench of the converter control block with random mode cases.
// Assumes the trigger model and the bound checker sit beside the design.
module tb_adc_channel_mode_trigger_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import acm_pkg::*;
    logic clock, nrst, wbCyc, wbStb, wbWe, wbAck, fire, converting, endFlag;
    logic pulseTimerTrig, eightBitTimerTrig, externalTriggerPinN;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, rdVal, seed;
    logic [9:0] sampleData, base;
    logic [2:0] sampleChan;
    logic [1:0] fireCode;
    logic [10:0] expRes [8];
    int err_total, samples_checked;
    acm_ctrl acm_ctrl_inst (.clock, .nrst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
        .wbDatO, .wbAck, .pulseTimerTrig, .eightBitTimerTrig, .externalTriggerPinN,
        .sampleData, .sampleChan, .converting, .endFlag);
    acm_trig_src acm_trig_src_inst (.clock, .nrst, .fire, .fireCode, .pulseTimerTrig,
        .eightBitTimerTrig, .externalTriggerPinN);
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a sample word that names its channel so misplaced stores show.
    always #50 clock = ~clock;
    always @(posedge clock) sampleData <= base ^ {7'h00, sampleChan};
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge clock);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'h3, we, a, 24'h00_0000, d};
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (wbAck !== 1'h1 && i < 20);
        rdVal = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'h0;
        if (i >= 20) chk("bus ack", 1, 0);
        if (i >= 20) give_verdict();
    endtask : wb
    // Bounded wait for the end flag or for conversion to stop.
    task automatic await(input logic forEnd, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clock);
            if (forEnd ? endFlag === 1'h1 : converting === 1'h0) break;
        end
        if (i >= lim) chk("wait", 1, 0);
        if (i >= lim) give_verdict();
    endtask : await
    task automatic fireSrc(input logic [1:0] c);
        @(posedge clock);
        {fireCode, fire} <= {c, 1'h1};
        @(posedge clock);
        fire <= 1'h0;
    endtask : fireSrc
    // Wrong sources first, then the selected start, then every result is read back.
    task automatic run_case(input logic [1:0] trig, md, clk, input logic [3:0] ch);
        logic [2:0] first;
        int n;
        seed = xs(seed);
        base = seed[9:0];
        wb(1'h1, 8'h04, {trig, md, clk, 2'h0});
        wb(1'h1, 8'h00, {4'h0, ch});
        for (n = 1; n < 4; n++) if (n != trig) fireSrc(n[1:0]);
        repeat (12) @(posedge clock);
        chk("idle converting", 0, {31'h0, converting});
        if (trig == 2'h0) wb(1'h1, 8'h00, {4'h2, ch});
        else fireSrc(trig);
        if (ch[3]) repeat (700) @(posedge clock);
        if (ch[3]) chk("end flag", 0, {31'h0, endFlag});
        else await(1'h1, 5000);
        wb(1'h0, 8'h00, 8'h00);
        if (!ch[3]) chk("start bit", {31'h0, md[1]}, {31'h0, rdVal[5]});
        if (!ch[3]) chk("end flag bit", 1, {31'h0, rdVal[7]});
        first = md[1] ? (md[0] ? 3'h0 : {ch[2], 2'h0}) : ch[2:0];
        wb(1'h1, 8'h00, 8'h00);
        await(1'h0, 600);
        wb(1'h1, 8'h00, 8'h00);
        for (n = 0; n < 8; n++) begin
            if (!ch[3] && n >= first && n <= ch[2:0]) expRes[n] = {1'h1, base ^ 10'(n)};
            wb(1'h0, 8'h20 + 8'(4 * n), 8'h00);
            if (expRes[n][10]) chk("result", {16'h0, expRes[n][9:0], 6'h0}, rdVal);
        end
    endtask : run_case
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clock, nrst, wbCyc, wbStb, wbWe, fire, fireCode, wbAdr} = '0;
        {wbDatI, wbSel, sampleData, base} = {32'h0, 4'hF, 20'h0_0000};
        {seed, err_total, samples_checked} = {32'h0000_326E, 64'h0};
        foreach (expRes[i]) expRes[i] = 11'h000;
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        wb(1'h0, 8'h00, 8'h00);
        chk("control status", 0, rdVal);
        wb(1'h0, 8'h04, 8'h00);
        chk("trigger mode", 0, rdVal);
        wbSel <= 4'h0;
        wb(1'h1, 8'h04, 8'hFF);
        wbSel <= 4'hF;
        wb(1'h0, 8'h04, 8'h00);
        chk("masked write", 0, rdVal);
        wb(1'h1, 8'h04, 8'hFF);
        wb(1'h0, 8'h04, 8'h00);
        chk("trigger mode", 32'h0000_00FC, rdVal);
        wb(1'h1, 8'h80, 8'hFF);
        wb(1'h0, 8'h80, 8'h00);
        chk("unmapped", 0, rdVal);
        run_case(2'h0, 2'h0, 2'h3, 4'h5);
        run_case(2'h1, 2'h1, 2'h2, 4'h7);
        run_case(2'h2, 2'h2, 2'h1, 4'h6);
        run_case(2'h3, 2'h2, 2'h0, 4'h3);
        run_case(2'h0, 2'h3, 2'h3, 4'h4);
        run_case(2'h1, 2'h3, 2'h2, 4'h7);
        run_case(2'h2, 2'h0, 2'h3, 4'h8);
        run_case(2'h0, 2'h3, 2'h1, 4'hC);
        run_case(2'h3, 2'h0, 2'h3, 4'h0);
        repeat (4) begin
            seed = xs(seed);
            run_case(seed[1:0], seed[3:2], seed[5:4], seed[9:6]);
        end
        give_verdict();
    end
endmodule : tb_adc_channel_mode_trigger_ctrl

// File: hdl/acm_ctrl.sv
// Channel, mode, trigger and conversion-time control of a ten-bit converter.
// Assumes a classic Wishbone master, one-cycle trigger pulses from the timers,
// and an analog core that returns one sample word when asked.
// Summary of operation
// - Single mode converts channel codes zero to seven.
// - Four-scan covers bank base up to low bits.
// - Eight-scan covers input zero up to n.
// - Trigger code zero: only software starts.
// - Trigger code one: pulse timer starts.
// - Trigger code two: eight-bit timer starts.
// - Trigger code three: external pin starts.
// - Scan enable low means single mode.
// - Mode ten scan_size_bit up to four channels.
// - Mode eleven scan_size_bit up to eight channels.
// - Clock select sets 530/266/134/68 states.
// - Low two trigger register bits read zero.
// - Pin falling edge sets start, begins conversion.
// - Start bit begins; single self-clears, scan holds.
// - Scan stores each result, then restarts group.
`include "acm_defines.svh"
module acm_ctrl (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Wishbone slave.
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    // Start triggers.
    input wire logic pulseTimerTrig,
    input wire logic eightBitTimerTrig,
    input wire logic externalTriggerPinN,
    // Analog core.
    input wire logic [9:0] sampleData,
    output logic [2:0] sampleChan,
    output logic converting,
    output logic endFlag
);
    import acm_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Register map, byte offsets on the bus.
    // Offset 0x00 is control and status: bit 7 end flag, bit 6 interrupt enable,
    // bit 5 start, bit 4 reads zero, and bits 3 to 0 the channel field.
    // Writing zero to the end flag clears it; writing one leaves it alone.
    // Offset 0x04 is trigger, mode and clock: bits 7 and 6 trigger source,
    // bit 5 scan enable, bit 4 scan size, and bits 3 and 2 clock select.
    // Bits 1 and 0 of that register are not stored and always read as zero.
    // Offsets 0x20 to 0x3C hold the eight results, one word per input,
    // with the ten result bits in bits 15 to 6 of the word.
    // Every other offset reads zero and ignores writes, but it is still acked
    // so that a stray access cannot hang the master.

    // Bus timing.
    // A request is seen on the edge where cyc and stb are high and ack is low.
    // Register and unmapped accesses raise ack on that edge.
    // Result reads take one more edge, because the result memory registers
    // its read data; ack and data then rise together.
    // A write lands on the edge where the master samples ack high, so the
    // master must hold address, data and select until that edge.
    // Only byte select 0 enables a write, since each register is one byte.

    // Conversion timing.
    // The start bit raises converting on the next edge.
    // One conversion lasts the selected number of states, one per clock.
    // The sample word is stored on the last state, for the current channel.
    // In scan mode every conversion of a pass uses the same length, which is
    // the figure chosen by the clock-select field; a single counter serves all.

    // Trigger notes.
    // Timer triggers are one-cycle pulses on this clock and need no sync.
    // The pin passes three flip-flops, so a start follows its falling edge
    // by five to six edges; a low pulse that spans fewer than two clock edges is lost.
    // A trigger while the start bit is already set does nothing more.
    // A trigger and a software clear of start in one cycle leave start set.
    // A channel code with bit 3 set never runs and never touches a result.

    ////////////////////////////////////////////////////////////////
    // Register state.
    logic [3:0] chanSel;
    logic startBit;
    logic intEnable;
    logic [1:0] trigSel;
    logic scanEnable;
    logic scanSize;
    logic [1:0] clockSel;
    logic [9:0] stateCount;
    logic [2:0] curChan;
    logic pinFall;
    logic [9:0] memRdData;
    logic readPending;
    logic storeEn;
    acm_result_t storeData;
    acm_group_t group;
    logic trigStart;
    logic busWrite;
    logic wrCs;
    logic wrTm;
    logic lastConv;
    logic [9:0] convLength;
    logic clearEnd;

    // Conversion length from the clock-select field.
    function automatic logic [9:0] conv_states(input logic [1:0] sel);
        unique case (sel)
            2'b00: conv_states = `ACM_CONV_STATES_0;
            2'b01: conv_states = `ACM_CONV_STATES_1;
            2'b10: conv_states = `ACM_CONV_STATES_2;
            2'b11: conv_states = `ACM_CONV_STATES_3;
        endcase
    endfunction : conv_states

    // Channel group from mode and channel field; top bit set is invalid.
    function automatic acm_group_t decode_group(input logic scanEn, input logic scanSz,
                                                input logic [3:0] ch);
        acm_group_t g;
        g.valid = !ch[3];
        if (!scanEn) begin
            g.first = ch[2:0];
            g.last = ch[2:0];
        end else if (!scanSz) begin
            g.first = {ch[2], 2'b00};
            g.last = ch[2:0];
        end else begin
            g.first = 3'b000;
            g.last = ch[2:0];
        end
        decode_group = g;
    endfunction : decode_group

    ////////////////////////////////////////////////////////////////
    // Bus decode; a write lands on the edge where the master samples ack high.
    assign busWrite = wbCyc && wbStb && wbWe && wbAck && wbSel[0];
    assign wrCs = busWrite && (wbAdr == `ACM_OFS_CTRL_STATUS);
    assign wrTm = busWrite && (wbAdr == `ACM_OFS_TRIG_MODE);
    assign group = decode_group(scanEnable, scanSize, chanSel);
    assign convLength = conv_states(clockSel);
    assign lastConv = converting && (stateCount == convLength - 10'd1);

    // Trigger source selection; code zero leaves software as the only start.
    always_comb begin
        unique case (acm_trig_t'(trigSel))
            ACM_TRIG_NONE: trigStart = 1'b0;
            ACM_TRIG_PULSE: trigStart = pulseTimerTrig;
            ACM_TRIG_TIMER8: trigStart = eightBitTimerTrig;
            ACM_TRIG_PIN: trigStart = pinFall;
        endcase
    end

    acm_pin_sync u_pin_sync (
        .clock(clock),
        .nrst(nrst),
        .pinN(externalTriggerPinN),
        .fallPulse(pinFall)
    );

    assign storeEn = lastConv && group.valid;
    assign storeData = '{chan: curChan, data: sampleData};

    acm_result_mem u_result_mem (
        .clock(clock),
        .nrst(nrst),
        .wrEn(storeEn),
        .wrData(storeData),
        .rdAddr(wbAdr[4:2]),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////
    // Trigger/mode/clock register; software keeps it still while started.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trigSel <= 2'b00;
            scanEnable <= 1'b0;
            scanSize <= 1'b0;
            clockSel <= 2'b00;
        end else if (wrTm) begin
            trigSel <= wbDatI[`ACM_TM_TRIG_HI:`ACM_TM_TRIG_LO];
            scanEnable <= wbDatI[`ACM_TM_SCAN_EN];
            scanSize <= wbDatI[`ACM_TM_SCAN_SIZE];
            clockSel <= wbDatI[`ACM_TM_CLK_HI:`ACM_TM_CLK_LO];
        end
    end

    // Channel field and interrupt enable bit.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chanSel <= 4'h0;
            intEnable <= 1'b0;
        end else if (wrCs) begin
            chanSel <= wbDatI[`ACM_CS_CHAN_HI:`ACM_CS_CHAN_LO];
            intEnable <= wbDatI[`ACM_CS_INT_EN];
        end
    end

    // Start bit: set by software or trigger, cleared by software or single-mode end.
    // A trigger in the same cycle as a software clear wins, so no start is lost.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            startBit <= 1'b0;
        end else if (trigStart) begin
            startBit <= 1'b1;
        end else if (wrCs) begin
            startBit <= wbDatI[`ACM_CS_START];
        end else if (lastConv && !scanEnable && curChan == group.last) begin
            startBit <= 1'b0;
        end
    end

    // End flag: set at group end; only writing zero clears it; set wins.
    assign clearEnd = wrCs && !wbDatI[`ACM_CS_END_FLAG];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            endFlag <= 1'b0;
        end else if (lastConv && group.valid && curChan == group.last) begin
            endFlag <= 1'b1;
        end else if (clearEnd) begin
            endFlag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer: counts states of one conversion and walks the group.
    // A prohibited code never runs, so no result register is touched.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            converting <= 1'b0;
            stateCount <= 10'd0;
            curChan <= 3'd0;
        end else if (!startBit || !group.valid) begin
            converting <= 1'b0;
            stateCount <= 10'd0;
            curChan <= group.first;
        end else if (!converting) begin
            converting <= 1'b1;
            stateCount <= 10'd0;
            curChan <= group.first;
        end else if (lastConv) begin
            stateCount <= 10'd0;
            if (curChan == group.last) begin
                curChan <= group.first;
                converting <= scanEnable;
            end else begin
                curChan <= curChan + 3'd1;
            end
        end else begin
            stateCount <= stateCount + 10'd1;
        end
    end

    // Channel shown to the analog core.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sampleChan <= 3'd0;
        end else begin
            sampleChan <= curChan;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus answer: result reads wait one cycle for the memory register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wbAck <= 1'b0;
            wbDatO <= 32'h0000_0000;
            readPending <= 1'b0;
        end else begin
            wbAck <= 1'b0;
            readPending <= 1'b0;
            if (readPending) begin
                wbAck <= 1'b1;
                wbDatO <= {16'h0000, memRdData, 6'b00_0000};
            end else if (wbCyc && wbStb && !wbAck) begin
                if (!wbWe && wbAdr >= `ACM_OFS_RESULT_BASE
                    && wbAdr[7:5] == 3'b001 && wbAdr[1:0] == 2'b00) begin
                    readPending <= 1'b1;
                end else begin
                    wbAck <= 1'b1;
                    unique case (wbAdr)
                        `ACM_OFS_CTRL_STATUS:
                            wbDatO <= {24'h00_0000, endFlag, intEnable, startBit, 1'b0,
                                       chanSel};
                        `ACM_OFS_TRIG_MODE:
                            wbDatO <= {24'h00_0000, trigSel, scanEnable, scanSize,
                                       clockSel, 2'b00};
                        default:
                            wbDatO <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end
endmodule : acm_ctrl

// File: hdl/acm_defines.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes inclusion by bare name from the control module acm_ctrl.
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

// Register byte offsets on the Wishbone bus.
`define ACM_OFS_CTRL_STATUS 8'h00
`define ACM_OFS_TRIG_MODE 8'h04
`define ACM_OFS_RESULT_BASE 8'h20

// Control/status register fields.
`define ACM_CS_END_FLAG 7
`define ACM_CS_INT_EN 6
`define ACM_CS_START 5
`define ACM_CS_CHAN_HI 3
`define ACM_CS_CHAN_LO 0

// Trigger/mode/clock register fields.
`define ACM_TM_TRIG_HI 7
`define ACM_TM_TRIG_LO 6
`define ACM_TM_SCAN_EN 5
`define ACM_TM_SCAN_SIZE 4
`define ACM_TM_CLK_HI 3
`define ACM_TM_CLK_LO 2
`define ACM_TM_WRITE_MASK 8'hFC

// Reset values.
`define ACM_CS_RESET 8'h00
`define ACM_TM_RESET 8'h00

// Conversion times in states, one state per clock.
`define ACM_CONV_STATES_0 10'd530
`define ACM_CONV_STATES_1 10'd266
`define ACM_CONV_STATES_2 10'd134
`define ACM_CONV_STATES_3 10'd68

`endif

// File: hdl/acm_pin_sync.sv
// Three-stage synchroniser and falling-edge detector for the trigger pin.
// Assumes an asynchronous active-low pin idling high.
module acm_pin_sync (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Pin and result.
    input wire logic pinN,
    output logic fallPulse
);
    import acm_pkg::*;
    logic stage1;
    logic stage2;
    logic stage3;
    logic level;

    ////////////////////////////////////////////////////////////////
    // Reset to the idle high level so no false edge appears at release.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= pinN;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level <= 1'b1;
            fallPulse <= 1'b0;
        end else begin
            if (stage2 == stage3) begin
                level <= stage3;
            end
            fallPulse <= (stage2 == stage3) && level && !stage3;
        end
    end
endmodule : acm_pin_sync

// File: hdl/acm_pkg.sv
// Types shared by the converter control block.
// Assumes the defines header sits next to it.
package acm_pkg;
    typedef enum logic [1:0] {ACM_TRIG_NONE, ACM_TRIG_PULSE, ACM_TRIG_TIMER8, ACM_TRIG_PIN} acm_trig_t;
    typedef struct packed {
        logic valid;
        logic [2:0] first;
        logic [2:0] last;
    } acm_group_t;
    typedef struct packed {
        logic [2:0] chan;
        logic [9:0] data;
    } acm_result_t;
endpackage : acm_pkg

// File: hdl/acm_result_mem.sv
// Eight result words, one per analog input, with registered read data.
// Assumes one writer (the sequencer) and one reader (the bus slave).
module acm_result_mem (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Write side.
    input wire logic wrEn,
    input wire acm_pkg::acm_result_t wrData,
    // Read side.
    input wire logic [2:0] rdAddr,
    output logic [9:0] rdData
);
    import acm_pkg::*;
    logic [9:0] mem [0:7];

    ////////////////////////////////////////////////////////////////
    // Storage is cleared at reset so reads are always defined.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= 10'h000;
            end
        end else if (wrEn) begin
            mem[wrData.chan] <= wrData.data;
        end
    end

    // Read data comes from a register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData <= 10'h000;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : acm_result_mem
